// File: pixel_cmd_cfg.svh
`ifndef PIXEL_CMD_CFG_SVH
`define PIXEL_CMD_CFG_SVH
// ****************************************
// Register map
// ****************************************
`define REG_CMD 8'h00
`define REG_CFG 8'h04
`define REG_COUNT 8'h08
`define REG_FG 8'h0C
`define REG_BG 8'h10
`define REG_IGN 8'h14
`define REG_IN 8'h18
`define REG_OUT 8'h1C
`define REG_STAT 8'h20
`define REG_INT 8'h24
`define REG_MASK 8'h28
`define REG_DMA 8'h2C
`define REG_BASE 8'h30
// ****************************************
// Fields and reset values
// ****************************************
`define CFG_BG_EN 0
`define CFG_IGN_EN 1
`define CFG_REQ_LSB 8
`define CFG_REQ_MSB 13
`define CFG_RST 32'h0000_0001
`define MASK_RST 4'h0
`define DMA_RST 7'h00
`define INT_DONE 0
`define INT_HALF 1
`define INT_REFUSED 2
`define INT_STALL 3
`define STAT_LVL_LSB 8
// ****************************************
// Command codes
// ****************************************
`define OP_NOP 4'h0
`define OP_SOFT_RESET 4'h1
`define OP_TEXT_BM 4'h2
`define OP_TEXT_CP 4'h3
`define OP_BITMAP_BM 4'h4
`define OP_BITMAP_CP 4'h5
`define OP_READ_BACK 4'h6
`define OP_EXCHANGE 4'h7
`define OP_PHYS_AREA 4'h8
// ****************************************
// Output FIFO
// ****************************************
`define FIFO_DEPTH 7'h40
`define FIFO_HALF 7'h20
`endif

// File: pixel_cmd_pkg.sv
package pixel_cmd_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOAD,
        ST_STOP,
        ST_GROUP,
        ST_READ,
        ST_STALL,
        ST_AREA
    } state_t;
endpackage

// File: pixel_filter.sv
`timescale 1ns/100ps
`include "pixel_cmd_cfg.svh"

// Decides whether a loaded pixel reaches video memory, and its colour.
module pixel_filter (
    input logic [3:0] op,
    input logic bg_en,
    input logic ign_en,
    input logic [31:0] pixel,
    input logic [23:0] fg,
    input logic [23:0] bg,
    input logic [23:0] ign,
    output logic write_en,
    output logic [23:0] colour
);
    logic [23:0] bmp;

    // Palette variants carry an 8-bit index, the others a direct colour.
    assign bmp = (op == `OP_BITMAP_CP) ? {16'h0000, pixel[7:0]}
                                       : pixel[23:0];

    always_comb begin
        write_en = 1'b0;
        colour = bmp;
        case (op)
            `OP_TEXT_BM, `OP_TEXT_CP: begin
                colour = pixel[0] ? fg : bg;
                write_en = pixel[0] || bg_en; // see RULE2
            end
            `OP_BITMAP_BM, `OP_BITMAP_CP: begin
                write_en = !(ign_en && bmp == ign); // see RULE3
            end
            default: begin
                write_en = 1'b0;
            end
        endcase
    end
endmodule // pixel_filter

// File: out_fifo.sv
`timescale 1ns/100ps
`include "pixel_cmd_cfg.svh"

// Output FIFO; a push while full or a pop while empty is ignored.
module out_fifo (
    input logic clk_sys,
    input logic reset,
    input logic clear,
    input logic push,
    input logic [31:0] push_data,
    input logic pop,
    output logic [31:0] head,
    output logic [6:0] level,
    output logic full,
    output logic empty
);
    logic [31:0] mem [0:63];
    logic [5:0] wr_q;
    logic [5:0] rd_q;
    logic [6:0] lvl_q;
    logic do_push;
    logic do_pop;

    assign full = lvl_q == `FIFO_DEPTH;
    assign empty = lvl_q == 7'h00;
    assign do_push = push && !full;
    assign do_pop = pop && !empty;
    assign head = mem[rd_q];
    assign level = lvl_q;

    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            mem[wr_q] <= push_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || clear) begin
            wr_q <= 6'h00;
            rd_q <= 6'h00;
            lvl_q <= 7'h00;
        end else begin
            wr_q <= wr_q + {5'h00, do_push};
            rd_q <= rd_q + {5'h00, do_pop};
            lvl_q <= lvl_q + {6'h00, do_push} - {6'h00, do_pop};
        end
    end
endmodule // out_fifo

// File: pixel_cmd_ctrl.sv
`timescale 1ns/100ps
`include "pixel_cmd_cfg.svh"

// Operation
// RULE1: Two text and two bitmap rectangle loads write video memory.
// RULE2: Text loads skip background pixels when background is disabled.
// RULE3: Bitmap loads skip ignore-colour pixels when ignoring is enabled.
// RULE4: The memory stream of a load may end before the command closes.
// RULE5: The engine reports ready only after the controller stopped it.
// RULE6: The host follows a suppressing load with a no-op and a reset.
// RULE7: A no-op runs only once the previous command is fully closed.
// RULE8: The host resets with a reset command followed by a no-op.
// RULE9: The host needs no such sequence before ordinary commands.
// RULE10: A read-back group starts only when count plus one words fit.
// RULE11: A space stall survives later commands until space is freed.
// RULE12: A stall ends once the level drops below depth-count-1.
// RULE13: The physical-area read ignores the request count and group stall.
// RULE14: The host sizes read-back packages to whole groups of count+1.
// RULE15: A half-full flag is polled or interrupts; a DMA limit is set.
// RULE16: After reset and no-op the controller is idle and takes commands.
module pixel_cmd_ctrl (
    input logic clk_sys,
    input logic reset,
    input logic [7:0] reg_addr,
    input logic [31:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic vm_we,
    output logic [19:0] vm_waddr,
    output logic [23:0] vm_wdata,
    output logic vm_re,
    output logic [19:0] vm_raddr,
    input logic [23:0] vm_rdata,
    output logic dma_req,
    output logic irq
);
    // ****************************************
    // Declarations
    // ****************************************
    pixel_cmd_pkg::state_t state_q;
    logic [3:0] op_q;
    logic [5:0] req_q;
    logic [15:0] idx_q;
    logic [6:0] left_q;
    logic stop_q;
    logic done_q;
    logic [31:0] cfg_q;
    logic [15:0] count_q;
    logic [23:0] fg_q;
    logic [23:0] bg_q;
    logic [23:0] ign_q;
    logic [19:0] base_q;
    logic [3:0] mask_q;
    logic [3:0] int_q;
    logic [6:0] dma_q;
    logic half_q;
    logic [31:0] rdata_q;
    logic vm_we_q;
    logic [19:0] vm_waddr_q;
    logic [23:0] vm_wdata_q;
    logic vm_re_q;
    logic [19:0] vm_raddr_q;
    logic pend_q;
    logic [19:0] pend_addr_q;
    logic [3:0] op_w;
    logic cmd_wr;
    logic sr_take;
    logic idle;
    logic op_known;
    logic is_load_w;
    logic is_rb_w;
    logic cmd_take;
    logic cmd_refuse;
    logic in_wr;
    logic in_flight;
    logic count_end;
    logic engine_ready;
    logic [6:0] need_w;
    logic [6:0] free_w;
    logic [6:0] resume_w;
    logic group_fit;
    logic area_issue;
    logic stall_evt;
    logic done_evt;
    logic filt_we;
    logic [23:0] filt_colour;
    logic fifo_pop;
    logic [31:0] fifo_head;
    logic [6:0] level;
    logic fifo_full;
    logic fifo_empty;
    logic half;
    logic [3:0] int_set;
    logic [3:0] int_clr;
    logic [19:0] cur_addr;

    // ****************************************
    // Decode
    // ****************************************
    assign op_w = reg_wdata[3:0];
    assign cmd_wr = reg_wr && reg_addr == `REG_CMD;
    assign sr_take = cmd_wr && op_w == `OP_SOFT_RESET;
    assign idle = state_q == pixel_cmd_pkg::ST_IDLE;
    assign op_known = op_w <= `OP_PHYS_AREA;
    assign is_load_w = op_w >= `OP_TEXT_BM && op_w <= `OP_BITMAP_CP;
    assign is_rb_w = op_w == `OP_READ_BACK || op_w == `OP_EXCHANGE;
    // A new command is taken only once the previous one closed.
    assign cmd_take = cmd_wr && !sr_take && idle && op_known; // see RULE7
    assign cmd_refuse = cmd_wr && !sr_take && !(idle && op_known);
    assign in_wr = reg_wr && reg_addr == `REG_IN
                   && state_q == pixel_cmd_pkg::ST_LOAD;
    assign in_flight = vm_re_q || pend_q;
    assign count_end = idx_q == count_q;
    assign cur_addr = base_q + {4'h0, idx_q};
    // The engine's ready is gated by the controller's stop.
    assign engine_ready = state_q == pixel_cmd_pkg::ST_STOP
                          && stop_q && done_q; // see RULE5
    assign need_w = {1'b0, req_q} + 7'h01;
    assign free_w = `FIFO_DEPTH - level;
    assign resume_w = `FIFO_DEPTH - {1'b0, req_q} - 7'h01;
    assign group_fit = free_w >= need_w; // see RULE10
    assign area_issue = state_q == pixel_cmd_pkg::ST_AREA
                        && !in_flight && !count_end && !fifo_full;
    assign stall_evt = state_q == pixel_cmd_pkg::ST_GROUP && !in_flight
                       && !count_end && !group_fit;
    assign done_evt = (cmd_take && op_w == `OP_NOP) || sr_take
                      || engine_ready
                      || ((state_q == pixel_cmd_pkg::ST_GROUP
                           || state_q == pixel_cmd_pkg::ST_AREA)
                          && count_end && !in_flight);
    assign fifo_pop = reg_rd && reg_addr == `REG_OUT && !fifo_empty;
    assign half = level >= `FIFO_HALF;

    pixel_filter u_filter (
        .op(op_q),
        .bg_en(cfg_q[`CFG_BG_EN]),
        .ign_en(cfg_q[`CFG_IGN_EN]),
        .pixel(reg_wdata),
        .fg(fg_q),
        .bg(bg_q),
        .ign(ign_q),
        .write_en(filt_we),
        .colour(filt_colour)
    );

    out_fifo u_fifo (
        .clk_sys(clk_sys),
        .reset(reset),
        .clear(sr_take),
        .push(pend_q),
        .push_data({8'h00, vm_rdata}),
        .pop(fifo_pop),
        .head(fifo_head),
        .level(level),
        .full(fifo_full),
        .empty(fifo_empty)
    );

    // ****************************************
    // Command sequencer
    // ****************************************
    // Soft reset returns the sequencer, read port and output FIFO to their initial state at once; registers keep their values.
    always_ff @(posedge clk_sys) begin
        if (reset || sr_take) begin // see RULE16
            state_q <= pixel_cmd_pkg::ST_IDLE;
            idx_q <= 16'h0000;
            left_q <= 7'h00;
            stop_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            case (state_q)
                pixel_cmd_pkg::ST_IDLE: begin
                    if (cmd_take) begin
                        idx_q <= 16'h0000;
                        stop_q <= 1'b0;
                        done_q <= 1'b0;
                        if (is_load_w) begin // see RULE1
                            if (count_q == 16'h0000) begin
                                done_q <= 1'b1;
                                state_q <= pixel_cmd_pkg::ST_STOP;
                            end else begin
                                state_q <= pixel_cmd_pkg::ST_LOAD;
                            end
                        end else if (is_rb_w) begin
                            state_q <= pixel_cmd_pkg::ST_GROUP;
                        end else if (op_w == `OP_PHYS_AREA) begin
                            state_q <= pixel_cmd_pkg::ST_AREA;
                        end
                    end
                end
                pixel_cmd_pkg::ST_LOAD: begin
                    // The last pixel closes the stream, written or not.
                    if (in_wr) begin // see RULE4
                        idx_q <= idx_q + 16'h0001;
                        if (idx_q + 16'h0001 == count_q) begin
                            done_q <= 1'b1;
                            state_q <= pixel_cmd_pkg::ST_STOP;
                        end
                    end
                end
                pixel_cmd_pkg::ST_STOP: begin
                    if (engine_ready) begin // see RULE5
                        state_q <= pixel_cmd_pkg::ST_IDLE;
                    end else begin
                        stop_q <= 1'b1;
                    end
                end
                pixel_cmd_pkg::ST_GROUP: begin
                    if (!in_flight) begin
                        if (count_end) begin
                            state_q <= pixel_cmd_pkg::ST_IDLE;
                        end else if (group_fit) begin // see RULE10
                            left_q <= need_w;
                            state_q <= pixel_cmd_pkg::ST_READ;
                        end else begin
                            state_q <= pixel_cmd_pkg::ST_STALL;
                        end
                    end
                end
                pixel_cmd_pkg::ST_READ: begin
                    idx_q <= idx_q + 16'h0001;
                    left_q <= left_q - 7'h01;
                    if (left_q == 7'h01 || idx_q + 16'h0001 == count_q) begin
                        state_q <= pixel_cmd_pkg::ST_GROUP;
                    end
                end
                pixel_cmd_pkg::ST_STALL: begin
                    // Only drained space or a reset releases the stall.
                    if (level < resume_w) begin // see RULE11, RULE12
                        state_q <= pixel_cmd_pkg::ST_GROUP;
                    end
                end
                pixel_cmd_pkg::ST_AREA: begin
                    if (!in_flight && count_end) begin
                        state_q <= pixel_cmd_pkg::ST_IDLE;
                    end else if (area_issue) begin // see RULE13
                        idx_q <= idx_q + 16'h0001;
                    end
                end
                default: begin
                    state_q <= pixel_cmd_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            op_q <= `OP_NOP;
            req_q <= 6'h00;
        end else if (cmd_take) begin
            op_q <= op_w;
            req_q <= cfg_q[`CFG_REQ_MSB:`CFG_REQ_LSB];
        end
    end

    // ****************************************
    // Video memory port
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (reset || sr_take) begin
            vm_re_q <= 1'b0;
            vm_raddr_q <= 20'h00000;
            pend_q <= 1'b0;
            pend_addr_q <= 20'h00000;
        end else begin
            vm_re_q <= state_q == pixel_cmd_pkg::ST_READ || area_issue;
            vm_raddr_q <= cur_addr;
            pend_q <= vm_re_q;
            pend_addr_q <= vm_raddr_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            vm_we_q <= 1'b0;
            vm_waddr_q <= 20'h00000;
            vm_wdata_q <= 24'h000000;
        end else if (in_wr && filt_we) begin // see RULE2, RULE3
            vm_we_q <= 1'b1;
            vm_waddr_q <= cur_addr;
            vm_wdata_q <= filt_colour;
        end else if (pend_q && op_q == `OP_EXCHANGE) begin
            vm_we_q <= 1'b1;
            vm_waddr_q <= pend_addr_q;
            vm_wdata_q <= fg_q;
        end else begin
            vm_we_q <= 1'b0;
        end
    end

    assign vm_we = vm_we_q;
    assign vm_waddr = vm_waddr_q;
    assign vm_wdata = vm_wdata_q;
    assign vm_re = vm_re_q;
    assign vm_raddr = vm_raddr_q;

    // ****************************************
    // Registers, interrupts and read port
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cfg_q <= `CFG_RST;
            count_q <= 16'h0000;
            fg_q <= 24'h000000;
            bg_q <= 24'h000000;
            ign_q <= 24'h000000;
            base_q <= 20'h00000;
            mask_q <= `MASK_RST;
            dma_q <= `DMA_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                `REG_CFG: cfg_q <= reg_wdata;
                `REG_COUNT: count_q <= reg_wdata[15:0];
                `REG_FG: fg_q <= reg_wdata[23:0];
                `REG_BG: bg_q <= reg_wdata[23:0];
                `REG_IGN: ign_q <= reg_wdata[23:0];
                `REG_BASE: base_q <= reg_wdata[19:0];
                `REG_MASK: mask_q <= reg_wdata[3:0];
                `REG_DMA: dma_q <= reg_wdata[6:0];
                default: begin
                end
            endcase
        end
    end

    assign int_set = {stall_evt, cmd_refuse, half && !half_q, done_evt};
    assign int_clr = (reg_wr && reg_addr == `REG_INT) ? reg_wdata[3:0]
                                                      : 4'h0;

    // A set in the clearing cycle wins.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            int_q <= 4'h0;
            half_q <= 1'b0;
        end else begin
            int_q <= (int_q & ~int_clr) | int_set; // see RULE15
            half_q <= half;
        end
    end

    assign irq = |(int_q & mask_q);
    assign dma_req = dma_q != 7'h00 && level >= dma_q; // see RULE15

    always_ff @(posedge clk_sys) begin
        if (reset || !reg_rd) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            case (reg_addr)
                `REG_CFG: rdata_q <= cfg_q;
                `REG_COUNT: rdata_q <= {16'h0000, count_q};
                `REG_FG: rdata_q <= {8'h00, fg_q};
                `REG_BG: rdata_q <= {8'h00, bg_q};
                `REG_IGN: rdata_q <= {8'h00, ign_q};
                `REG_BASE: rdata_q <= {12'h000, base_q};
                `REG_MASK: rdata_q <= {28'h0000000, mask_q};
                `REG_DMA: rdata_q <= {25'h0000000, dma_q};
                `REG_INT: rdata_q <= {28'h0000000, int_q};
                `REG_OUT: rdata_q <= fifo_empty ? 32'h0000_0000 : fifo_head;
                `REG_STAT: rdata_q <= {17'h00000, level, 3'h0, fifo_full,
                    fifo_empty, state_q == pixel_cmd_pkg::ST_STALL,
                    half, !idle};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign reg_rdata = rdata_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    text_skip_a: assert property (in_wr && op_q == `OP_TEXT_BM // see RULE2
        && !cfg_q[`CFG_BG_EN] && !reg_wdata[0] |=> !vm_we)
        else $error("background pixel written");
    ign_skip_a: assert property (in_wr && op_q >= `OP_BITMAP_BM // see RULE3
        && cfg_q[`CFG_IGN_EN] && filt_colour == ign_q |=> !vm_we)
        else $error("ignore colour pixel written");
    bitmap_write_a: assert property (in_wr && op_q == `OP_BITMAP_BM // see RULE1
        && !cfg_q[`CFG_IGN_EN] |=> vm_we && vm_wdata == $past(filt_colour))
        else $error("bitmap pixel not written");
    load_close_a: assert property ( // see RULE4
        state_q == pixel_cmd_pkg::ST_LOAD && !sr_take
        |=> state_q inside {pixel_cmd_pkg::ST_LOAD, pixel_cmd_pkg::ST_STOP})
        else $error("load left without stop");
    stop_hold_a: assert property ( // see RULE5
        state_q == pixel_cmd_pkg::ST_STOP && !stop_q && !sr_take
        |=> state_q == pixel_cmd_pkg::ST_STOP ##1 idle)
        else $error("ready not held for stop");
    nop_idle_a: assert property (cmd_take && op_w == `OP_NOP // see RULE7
        |=> idle && int_q[`INT_DONE])
        else $error("no-op did not complete");
    group_fit_a: assert property ( // see RULE10
        state_q == pixel_cmd_pkg::ST_GROUP && !in_flight && !count_end
        && !sr_take && free_w < need_w |=> state_q == pixel_cmd_pkg::ST_STALL)
        else $error("group started without space");
    stall_hold_a: assert property ( // see RULE11
        state_q == pixel_cmd_pkg::ST_STALL && level >= resume_w && !sr_take
        |=> state_q == pixel_cmd_pkg::ST_STALL)
        else $error("stall released without space");
    stall_resume_a: assert property ( // see RULE12
        state_q == pixel_cmd_pkg::ST_STALL && level < resume_w && !sr_take
        |=> state_q == pixel_cmd_pkg::ST_GROUP)
        else $error("stall not released");
    area_issue_a: assert property (area_issue && !sr_take // see RULE13
        |=> vm_re ##2 (level != 7'h00))
        else $error("area read not issued");
    half_int_a: assert property (half && !half_q // see RULE15
        |=> int_q[`INT_HALF])
        else $error("half flag not latched");
    reset_idle_a: assert property (sr_take // see RULE16
        |=> idle && level == 7'h00 && !vm_re)
        else $error("soft reset left state");

    load_done_c: cover property (state_q == pixel_cmd_pkg::ST_STOP
        && engine_ready && !cfg_q[`CFG_BG_EN]);
    stall_resume_c: cover property (state_q == pixel_cmd_pkg::ST_STALL
        ##1 state_q == pixel_cmd_pkg::ST_GROUP);
    area_done_c: cover property (state_q == pixel_cmd_pkg::ST_AREA
        ##1 idle);
endmodule // pixel_cmd_ctrl

// File: vmem_model.sv
`timescale 1ns/100ps
// Video memory: each word is its address with 5 in the top nibble; data stand one cycle.
module vmem_model (
    input wire logic clk_sys,
    input wire logic vm_re,
    input wire logic [19:0] vm_raddr,
    output logic [23:0] vm_rdata
);
    logic [23:0] data_q = 24'h000000;
    assign vm_rdata = data_q;
    // Outside the answer cycle the bus toggles so stale data never match.
    always @(posedge clk_sys) begin
        if (vm_re) begin
            data_q <= {4'h5, vm_raddr};
        end else begin
            data_q <= ~data_q;
        end
    end
endmodule // vmem_model

// File: tb_top.sv
`timescale 1ns/100ps
`include "pixel_cmd_cfg.svh"
module tb_top;
    localparam logic [23:0] FG = 24'h00A5C3;
    localparam logic [23:0] BG = 24'h3C0F00;
    localparam logic [23:0] IGN = 24'h000011;
    localparam logic [19:0] BASE = 20'h00100;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, v;
    logic vm_we, vm_re, dma_req, irq;
    logic [19:0] vm_waddr, vm_raddr, last_wa = 20'h00000;
    logic [23:0] vm_wdata, vm_rdata, last_col = 24'h000000;
    logic [31:0] lfsr_q = 32'h00000014;
    int bad_count = 0;
    int n_tests = 0;
    int wr_cnt = 0;
    int i, k;
    pixel_cmd_ctrl dut (.clk_sys(clk_sys), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vm_we(vm_we),
        .vm_waddr(vm_waddr), .vm_wdata(vm_wdata), .vm_re(vm_re),
        .vm_raddr(vm_raddr), .vm_rdata(vm_rdata), .dma_req(dma_req),
        .irq(irq));
    vmem_model mem (.clk_sys(clk_sys), .vm_re(vm_re),
        .vm_raddr(vm_raddr), .vm_rdata(vm_rdata));
    initial forever #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (vm_we) begin
            wr_cnt++;
            last_col = vm_wdata;
            last_wa = vm_waddr;
        end
    end
    // ****************************************
    // Bus tasks and expectations
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Returns the write enable above the colour of one loaded pixel.
    function automatic logic [24:0] pix(input logic [3:0] op,
        input logic [1:0] cf, input logic [31:0] d);
        logic [23:0] c;
        if (op < `OP_BITMAP_BM) return d[0] ? {1'b1, FG} : {cf[0], BG};
        c = (op == `OP_BITMAP_BM) ? d[23:0] : {16'h0000, d[7:0]};
        return {!(cf[1] && c == IGN), c};
    endfunction
    task end_sim;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge clk_sys);
    endtask
    task wait_stat(input int b, input logic val);
        for (int n = 0; n < 300; n++) begin
            rd(`REG_STAT);
            if (v[b] === val) return;
        end
        bad_count++;
        end_sim();
    endtask
    task pop(input logic [19:0] a);
        rd(`REG_OUT);
        chk({8'h00, v[23:0]}, {8'h00, 4'h5, BASE + a});
    endtask
    task load(input logic [3:0] op, input logic [1:0] cf, input int n);
        int w0, ew;
        logic [24:0] p;
        logic [23:0] ec;
        logic [19:0] ea;
        w0 = wr_cnt;
        ew = 0;
        ec = last_col;
        ea = last_wa;
        wr(`REG_CFG, {30'h0, cf});
        wr(`REG_COUNT, 32'(n));
        wr(`REG_CMD, {28'h0, op});
        for (int j = 0; j < n; j++) begin
            lfsr_q = lfsr(lfsr_q);
            v = lfsr_q;
            if (j == n - 1) begin
                v[23:0] = (op == `OP_BITMAP_BM) ? IGN : {v[23:8],
                    (op == `OP_BITMAP_CP) ? IGN[7:0] : 8'h10};
            end
            p = pix(op, cf, v);
            if (p[24]) begin
                ew++;
                ec = p[23:0];
                ea = BASE + 20'(j);
            end
            wr(`REG_IN, v);
        end
        wait_stat(0, 1'b0);
        chk(32'(wr_cnt - w0), 32'(ew));
        chk({8'h00, last_col}, {8'h00, ec});
        chk({12'h000, last_wa}, {12'h000, ea});
        rd(`REG_INT);
        chk({31'h0, v[`INT_DONE]}, 32'h1);
        if ((op < `OP_BITMAP_BM) ? !cf[0] : cf[1]) begin
            wr(`REG_CMD, {28'h0, `OP_NOP});
            wr(`REG_CMD, {28'h0, `OP_SOFT_RESET});
            wr(`REG_CMD, {28'h0, `OP_NOP});
        end
        wr(`REG_INT, 32'h0000000F);
        rd(`REG_STAT);
        chk({31'h0, v[0]}, 32'h0);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rd(`REG_CFG);
        chk(v, `CFG_RST);
        rd(`REG_MASK);
        chk(v, 32'h0);
        rd(8'h40);
        chk(v, 32'h0);
        wr(`REG_FG, {8'h00, FG});
        wr(`REG_BG, {8'h00, BG});
        wr(`REG_IGN, {8'h00, IGN});
        wr(`REG_BASE, {12'h000, BASE});
        for (k = 0; k < 8; k++) begin
            load(4'(2 + k / 2), k % 2 ? 2'b01 : (k < 4 ? 2'b00 : 2'b10),
                3 + k);
        end
        wr(`REG_CMD, 32'h0000000F);
        rd(`REG_INT);
        chk({31'h0, v[`INT_REFUSED]}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(`REG_INT, 32'h0000000F);
        wr(`REG_MASK, 32'h00000002);
        wr(`REG_DMA, 32'd56);
        wr(`REG_CFG, 32'h00000601);
        wr(`REG_COUNT, 32'd70);
        wr(`REG_CMD, {28'h0, `OP_READ_BACK});
        wait_stat(2, 1'b1);
        rd(`REG_STAT);
        chk({25'h0, v[14:8]}, 32'(`FIFO_DEPTH / 7 * 7));
        chk({30'h0, dma_req, irq}, 32'h3);
        wr(`REG_CMD, {28'h0, `OP_NOP});
        rd(`REG_INT);
        chk({30'h0, v[3:2]}, 32'h3);
        for (i = 0; i < 6; i++) pop(20'(i));
        rd(`REG_STAT);
        chk({25'h0, v[14:8]}, 32'd57);
        chk({31'h0, v[2]}, 32'h1);
        pop(20'd6);
        wait_stat(0, 1'b0);
        rd(`REG_STAT);
        chk({25'h0, v[14:8]}, 32'd63);
        for (i = 0; i < 63; i++) pop(20'(7 + i));
        wr(`REG_CFG, 32'h00000001);
        wr(`REG_COUNT, 32'd2);
        k = wr_cnt;
        wr(`REG_CMD, {28'h0, `OP_EXCHANGE});
        wait_stat(0, 1'b0);
        chk(32'(wr_cnt - k), 32'd2);
        chk({8'h00, last_col}, {8'h00, FG});
        chk({12'h000, last_wa}, {12'h000, BASE + 20'd1});
        // Two words stay queued so a full-size group could not fit here.
        wr(`REG_CFG, 32'h00003F01);
        wr(`REG_COUNT, 32'd3);
        wr(`REG_CMD, {28'h0, `OP_PHYS_AREA});
        wait_stat(0, 1'b0);
        rd(`REG_STAT);
        chk({25'h0, v[14:8]}, 32'd5);
        for (i = 0; i < 5; i++) pop(20'(i < 2 ? i : i - 2));
        rd(`REG_OUT);
        chk(v, 32'h0);
        wr(`REG_INT, 32'h0000000F);
        chk({31'h0, irq}, 32'h0);
        end_sim();
    end
endmodule // tb_top
